// file: bsia_consts.svh
// constants for the brake sequencer and terminal allocation block
`ifndef BSIA_CONSTS_SVH
`define BSIA_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define BSIA_OFF_SON_WAIT     4'h0
`define BSIA_OFF_WAIT_FLOW    4'h1
`define BSIA_OFF_BRK_SPEED    4'h2
`define BSIA_OFF_BRK_TIME     4'h3
`define BSIA_OFF_IN_ALLOC_LO  4'h4
`define BSIA_OFF_IN_ALLOC_HI  4'h5
`define BSIA_OFF_OUT_ALLOC    4'h6
`define BSIA_OFF_STATUS       4'h7
`define BSIA_OFF_CTRL         4'h8

// ----------------------------------------
// reset values
// ----------------------------------------
`define BSIA_RST_SON_WAIT     16'h0000
`define BSIA_RST_WAIT_FLOW    16'h0000
`define BSIA_RST_BRK_SPEED    16'h0064
`define BSIA_RST_BRK_TIME     16'h01f4
`define BSIA_RST_IN_ALLOC_LO  16'h3210
`define BSIA_RST_IN_ALLOC_HI  16'h7654
`define BSIA_RST_OUT_ALLOC    16'h0410

// ----------------------------------------
// output function codes
// ----------------------------------------
`define BSIA_OFN_BRAKE        4'h4

// ----------------------------------------
// timing: wait settings count in 1 ms units
// ----------------------------------------
`define BSIA_WAIT_UNIT_NS     1000000
`define BSIA_CLK_PERIOD_NS    25
`define BSIA_MS_CYCLES        (`BSIA_WAIT_UNIT_NS / `BSIA_CLK_PERIOD_NS)

`endif

// file: bsia_pkg.sv
// types for the brake sequencer and terminal allocation block
package bsia_pkg;
  typedef enum logic [4:0] {
    BSIA_OFF      = 5'b00001,
    BSIA_ON_DELAY = 5'b00010,
    BSIA_ON       = 5'b00100,
    BSIA_OFF_WAIT = 5'b01000,
    BSIA_HOLD     = 5'b10000
  } bsia_state_type;
endpackage

// file: bsia_alloc_if.sv
// allocation settings and routed functions between top and router
`timescale 1ns/1ps
interface bsia_alloc_if;
  logic [31:0] in_alloc;
  logic [11:0] out_alloc;
  logic [7:0]  term_in;
  logic [15:0] func_in;
  logic [10:0] func_out;
  logic [2:0]  term_out;
  modport top (output in_alloc, output out_alloc, output term_in, output func_out,
               input func_in, input term_out);
  modport router (input in_alloc, input out_alloc, input term_in, input func_out,
                  output func_in, output term_out);
endinterface

// file: bsia_router.sv
// routing of input terminals to functions and status functions to output pairs
`timescale 1ns/1ps
module bsia_router (
  bsia_alloc_if.router al
);
  // terminals sharing one function are or-ed together
  function automatic logic [15:0] bsia_route_in(input logic [31:0] sel, input logic [7:0] t);
    logic [15:0] f;
    f = 16'h0000;
    for (int i = 7; i >= 0; i--) begin
      f[sel[i*4 +: 4]] = t[i] | f[sel[i*4 +: 4]];
    end
    return f;
  endfunction

  function automatic logic bsia_pick_out(input logic [3:0] code, input logic [10:0] f);
    return (code <= 4'ha) ? f[code] : 1'b0;
  endfunction

  assign al.func_in     = bsia_route_in(al.in_alloc, al.term_in);
  assign al.term_out[0] = bsia_pick_out(al.out_alloc[3:0], al.func_out);
  assign al.term_out[1] = bsia_pick_out(al.out_alloc[7:4], al.func_out);
  assign al.term_out[2] = bsia_pick_out(al.out_alloc[11:8], al.func_out);
endmodule

// file: bsia_brake_seq.sv
// brake sequencing against excitation, with terminal allocation
//
// Behaviour
// - brake timing only acts when some output pair carries the brake code
// - negative wait: excitation first, brake output after delay magnitude
// - standard flow: brake engage and excitation removal happen together
// - after servo-off, brake engages once speed drops below wait speed
// - after servo-off, brake engages once elapsed time reaches wait time
// - brake engages on whichever of speed or time condition comes first
// - three-digit setting maps eleven status functions onto pairs, at restart
// - wait time, flow, speed and time settings act immediately
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
`include "bsia_consts.svh"
module bsia_brake_seq #(
  parameter int unsigned MS_CYCLES = `BSIA_MS_CYCLES
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // input terminals, asynchronous pins
  input  wire logic [7:0]  term_in,
  // motor feedback, same clock
  input  wire logic [15:0] motor_speed,
  // status functions, codes 0..a except brake, same clock
  input  wire logic [10:0] status_func,
  // outputs
  output logic [15:0] func_in,
  output logic [2:0]  term_out,
  output logic        brake_out,
  output logic        excite_out
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] son_wait_q, wait_flow_q, brk_speed_q, brk_time_q;
  logic [15:0] in_lo_q, in_hi_q, out_alloc_q;
  logic [15:0] in_lo_act_q, in_hi_act_q, out_act_q;
  logic [7:0]  term_s1_q, term_s2_q;
  logic [15:0] rdata_d, status_word;
  logic        restart_d;

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  logic we_son_wait, we_wait_flow, we_brk_speed, we_brk_time;
  logic we_in_lo, we_in_hi, we_out_alloc;

  // strobes carry the clock enable so a frozen block ignores the bus
  assign we_son_wait  = clk_en && reg_wr && reg_addr == `BSIA_OFF_SON_WAIT;
  assign we_wait_flow = clk_en && reg_wr && reg_addr == `BSIA_OFF_WAIT_FLOW;
  assign we_brk_speed = clk_en && reg_wr && reg_addr == `BSIA_OFF_BRK_SPEED;
  assign we_brk_time  = clk_en && reg_wr && reg_addr == `BSIA_OFF_BRK_TIME;
  assign we_in_lo     = clk_en && reg_wr && reg_addr == `BSIA_OFF_IN_ALLOC_LO;
  assign we_in_hi     = clk_en && reg_wr && reg_addr == `BSIA_OFF_IN_ALLOC_HI;
  assign we_out_alloc = clk_en && reg_wr && reg_addr == `BSIA_OFF_OUT_ALLOC;
  // restart loads pending allocation into the active copy
  assign restart_d = reg_wr && reg_addr == `BSIA_OFF_CTRL && reg_wdata[0];

  // wait settings written straight into live registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      son_wait_q  <= `BSIA_RST_SON_WAIT;
      wait_flow_q <= `BSIA_RST_WAIT_FLOW;
      brk_speed_q <= `BSIA_RST_BRK_SPEED;
      brk_time_q  <= `BSIA_RST_BRK_TIME;
    end else begin
      if (we_son_wait) begin
        son_wait_q <= reg_wdata;
      end
      if (we_wait_flow) begin
        wait_flow_q <= reg_wdata;
      end
      if (we_brk_speed) begin
        brk_speed_q <= reg_wdata;
      end
      if (we_brk_time) begin
        brk_time_q <= reg_wdata;
      end
    end
  end

  // pending allocation, inert until a restart copies it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      in_lo_q     <= `BSIA_RST_IN_ALLOC_LO;
      in_hi_q     <= `BSIA_RST_IN_ALLOC_HI;
      out_alloc_q <= `BSIA_RST_OUT_ALLOC;
    end else begin
      if (we_in_lo) begin
        in_lo_q <= reg_wdata;
      end
      if (we_in_hi) begin
        in_hi_q <= reg_wdata;
      end
      if (we_out_alloc) begin
        out_alloc_q <= reg_wdata;
      end
    end
  end

  // allocation takes effect only at restart
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      in_lo_act_q <= `BSIA_RST_IN_ALLOC_LO;
      in_hi_act_q <= `BSIA_RST_IN_ALLOC_HI;
      out_act_q   <= `BSIA_RST_OUT_ALLOC;
    end else if (clk_en && restart_d) begin
      in_lo_act_q <= in_lo_q;
      in_hi_act_q <= in_hi_q;
      out_act_q   <= {4'h0, out_alloc_q[11:0]};
    end
  end

  // ----------------------------------------
  // input synchroniser and routing
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      term_s1_q <= 8'h00;
      term_s2_q <= 8'h00;
    end else if (clk_en) begin
      term_s1_q <= term_in;
      term_s2_q <= term_s1_q;
    end
  end

  bsia_alloc_if al ();
  assign al.in_alloc  = {in_hi_act_q, in_lo_act_q};
  assign al.out_alloc = out_act_q[11:0];
  assign al.term_in   = term_s2_q;

  bsia_router u_router (
    .al (al)
  );

  // ----------------------------------------
  // brake sequencer
  // ----------------------------------------
  bsia_pkg::bsia_state_type state_q, state_d;
  logic [31:0] cnt_q, cnt_d;
  logic        brk_used, son, son_neg, flow_std;
  logic [31:0] son_mag_cyc, brk_time_cyc;
  logic        son_done, time_done, speed_low;
  logic        brake_d, excite_d;

  function automatic logic [31:0] bsia_ms_to_cyc(input logic [15:0] ms);
    return 32'(ms) * 32'(MS_CYCLES);
  endfunction

  // true when an output digit carries the brake function
  function automatic logic bsia_is_brake(input logic [3:0] code);
    return code == `BSIA_OFN_BRAKE;
  endfunction

  // brake timing only with a brake-coded output pair
  assign brk_used = bsia_is_brake(out_act_q[3:0]) || bsia_is_brake(out_act_q[7:4])
                    || bsia_is_brake(out_act_q[11:8]);
  assign son          = al.func_in[0];
  assign son_neg      = son_wait_q[15];
  assign son_mag_cyc  = bsia_ms_to_cyc(son_neg ? 16'(-son_wait_q) : son_wait_q);
  assign brk_time_cyc = bsia_ms_to_cyc(brk_time_q);
  assign son_done     = cnt_q + 32'h1 >= son_mag_cyc;
  // elapsed time reaches the wait time
  assign time_done    = cnt_q >= brk_time_cyc;
  assign speed_low    = motor_speed < brk_speed_q;
  assign flow_std     = wait_flow_q == 16'h0000;

  // brake_out high means brake released (relay energised)
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    brake_d  = 1'b0;
    excite_d = 1'b0;
    case (state_q)
      bsia_pkg::BSIA_OFF: begin
        cnt_d = 32'h0;
        if (son) begin
          // zero wait asserts both at once
          if (!brk_used || son_mag_cyc == 32'h0) begin
            state_d  = bsia_pkg::BSIA_ON;
            brake_d  = 1'b1;
            excite_d = 1'b1;
          end else begin
            state_d  = bsia_pkg::BSIA_ON_DELAY;
            brake_d  = !son_neg;
            excite_d = son_neg;
          end
        end
      end
      bsia_pkg::BSIA_ON_DELAY: begin
        brake_d  = !son_neg;
        excite_d = son_neg;
        cnt_d    = cnt_q + 32'h1;
        if (!son) begin
          state_d = bsia_pkg::BSIA_OFF;
          brake_d  = 1'b0;
          excite_d = 1'b0;
        end else if (son_done) begin
          state_d  = bsia_pkg::BSIA_ON;
          brake_d  = 1'b1;
          excite_d = 1'b1;
        end
      end
      bsia_pkg::BSIA_ON: begin
        brake_d  = 1'b1;
        excite_d = 1'b1;
        cnt_d    = 32'h0;
        if (!son) begin
          excite_d = 1'b0;
          // standard flow engages brake with servo-off
          if (!brk_used || flow_std) begin
            state_d = bsia_pkg::BSIA_OFF;
            brake_d = 1'b0;
          end else begin
            state_d = bsia_pkg::BSIA_OFF_WAIT;
          end
        end
      end
      bsia_pkg::BSIA_OFF_WAIT: begin
        brake_d = 1'b1;
        cnt_d   = cnt_q + 32'h1;
        if (speed_low || time_done) begin
          state_d = bsia_pkg::BSIA_HOLD;
          brake_d = 1'b0;
        end
      end
      bsia_pkg::BSIA_HOLD: begin
        // one settling cycle before a new servo-on
        state_d = bsia_pkg::BSIA_OFF;
      end
      default: begin
        state_d = bsia_pkg::BSIA_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q    <= bsia_pkg::BSIA_OFF;
      cnt_q      <= 32'h0;
      brake_out  <= 1'b0;
      excite_out <= 1'b0;
    end else if (clk_en) begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      brake_out  <= brake_d;
      excite_out <= excite_d;
    end
  end

  // ----------------------------------------
  // output routing, brake function in slot 4
  // ----------------------------------------
  // brake code drives the pair with the sequencer's brake signal
  assign al.func_out = {status_func[10:5], brake_d, status_func[3:0]};

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      term_out <= 3'h0;
      func_in  <= 16'h0000;
    end else if (clk_en) begin
      term_out <= al.term_out;
      func_in  <= al.func_in;
    end
  end

  // ----------------------------------------
  // status word
  // ----------------------------------------
  // bit6 brake pair allocated, bit5 released, bit4 excited, bit0 servo-on
  assign status_word = {9'h000, brk_used, brake_out, excite_out, 3'h0, son};

  // ----------------------------------------
  // register read
  // ----------------------------------------
  assign rdata_d = (reg_addr == `BSIA_OFF_SON_WAIT)    ? son_wait_q :
                   (reg_addr == `BSIA_OFF_WAIT_FLOW)   ? wait_flow_q :
                   (reg_addr == `BSIA_OFF_BRK_SPEED)   ? brk_speed_q :
                   (reg_addr == `BSIA_OFF_BRK_TIME)    ? brk_time_q :
                   (reg_addr == `BSIA_OFF_IN_ALLOC_LO) ? in_lo_q :
                   (reg_addr == `BSIA_OFF_IN_ALLOC_HI) ? in_hi_q :
                   (reg_addr == `BSIA_OFF_OUT_ALLOC)   ? out_alloc_q :
                   (reg_addr == `BSIA_OFF_STATUS)      ? status_word :
                   16'h0000;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rdata_d : 16'h0000;
    end
  end
endmodule

// file: bsia_brake_monitor.sv
// assertion checker for the brake sequencer ports
`timescale 1ns/1ps
`include "bsia_consts.svh"
module bsia_brake_monitor #(
  parameter int unsigned MS_CYCLES = `BSIA_MS_CYCLES
) (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        clk_en,
  // register port
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // sequencer
  input wire logic [15:0] motor_speed,
  input wire logic [15:0] func_in,
  input wire logic        brake_out,
  input wire logic        excite_out
);
  logic signed [15:0] wait_q;
  logic [15:0]        flow_q;
  logic [15:0]        spd_q;
  logic [15:0]        tim_q;
  logic [11:0]        pend_q;
  logic [11:0]        act_q;
  logic               ex_q;
  logic               offw_q;
  logic [31:0]        cnt_q;
  wire wr_ok = reg_wr && clk_en;
  wire brk_used = (act_q[3:0] == 4'h4) || (act_q[7:4] == 4'h4) || (act_q[11:8] == 4'h4);
  // shadow settings; allocation only counts after a restart
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      {wait_q, flow_q} <= {`BSIA_RST_SON_WAIT, `BSIA_RST_WAIT_FLOW};
      {spd_q, tim_q} <= {`BSIA_RST_BRK_SPEED, `BSIA_RST_BRK_TIME};
      pend_q <= 12'(`BSIA_RST_OUT_ALLOC);
      act_q  <= 12'(`BSIA_RST_OUT_ALLOC);
      {ex_q, offw_q, cnt_q} <= '0;
    end else begin
      if (wr_ok && reg_addr == 4'h0) wait_q <= reg_wdata;
      if (wr_ok && reg_addr == 4'h1) flow_q <= reg_wdata;
      if (wr_ok && reg_addr == 4'h2) spd_q <= reg_wdata;
      if (wr_ok && reg_addr == 4'h3) tim_q <= reg_wdata;
      if (wr_ok && reg_addr == 4'h6) pend_q <= reg_wdata[11:0];
      if (wr_ok && reg_addr == 4'h8 && reg_wdata[0]) act_q <= pend_q;
      ex_q <= excite_out;
      offw_q <= offw_q ? brake_out : (ex_q && !excite_out && brake_out && flow_q != 16'h0 && brk_used);
      cnt_q <= offw_q ? cnt_q + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence son_rise; $rose(func_in[0]); endsequence
  sequence slow_seen; offw_q && motor_speed < spd_q; endsequence
  a_zero_wait_sync: assert property (
    brk_used && wait_q == 16'sh0 && $rose(brake_out) |-> $rose(excite_out)) else $error("brake and excitation split");
  a_pos_brake_first: assert property (
    brk_used && wait_q > 16'sh0 && $rose(brake_out) |-> !excite_out) else $error("excitation before brake");
  a_neg_excite_first: assert property (
    brk_used && wait_q < 16'sh0 && $rose(excite_out) |-> !brake_out) else $error("brake before excitation");
  a_std_flow_same: assert property (
    brk_used && flow_q == 16'h0 && $fell(excite_out) && $past(brake_out) |-> !brake_out) else $error("brake late");
  a_speed_engage: assert property (
    slow_seen |-> ##[0:3] !brake_out) else $error("brake ignores low speed");
  a_time_engage: assert property (
    offw_q |-> cnt_q <= tim_q * MS_CYCLES + 4) else $error("brake wait time overrun");
  a_unused_timing: assert property (
    !brk_used ##0 son_rise |-> ##[1:3] excite_out) else $error("timing applied without brake pair");
  a_off_drop: assert property (
    $fell(func_in[0]) |-> ##[1:2] !excite_out) else $error("excitation kept at servo off");
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0) else $error("read data outside read slot");
endmodule
bind bsia_brake_seq bsia_brake_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (
  .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .motor_speed(motor_speed),
  .func_in(func_in), .brake_out(brake_out), .excite_out(excite_out));

// file: bsia_motor_model.sv
// motor and load model: speed follows excitation
`timescale 1ns/1ps
module bsia_motor_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // drive side
  input  wire logic        excite_out,
  input  wire logic        brake_out,
  input  wire logic [7:0]  decel,
  // feedback
  output logic      [15:0] motor_speed
);
  // coasting motor slows by decel per cycle, an engaged brake stops it dead
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      motor_speed <= 16'h0;
    end else if (excite_out) begin
      motor_speed <= (motor_speed >= 16'h0400) ? 16'h0400 : motor_speed + 16'h0010;
    end else if (!brake_out || motor_speed < {8'h0, decel}) begin
      motor_speed <= 16'h0;
    end else begin
      motor_speed <= motor_speed - {8'h0, decel};
    end
  end
endmodule

// file: testbench.sv
// self-checking testbench for the brake sequencer
`timescale 1ns/1ps
`include "bsia_consts.svh"
module testbench;
  logic        clk_sys = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, pv = 1'b0, rd_d = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0, reg_rdata, func_in, motor_speed, v;
  logic [7:0]  term_in = 8'h0, decel = 8'h40;
  logic [10:0] status_func = 11'h0;
  logic [2:0]  term_out;
  logic        brake_out, excite_out, clk_en = 1'b1;
  logic [31:0] al;
  logic [37:0] rq[$], pq[$];
  int          n_mismatch = 0, n_checks = 0, cyc = 0;
  bsia_brake_seq #(.MS_CYCLES(4)) u_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .term_in(term_in), .motor_speed(motor_speed),
    .status_func(status_func), .func_in(func_in), .term_out(term_out), .brake_out(brake_out),
    .excite_out(excite_out));
  bsia_motor_model u_motor (.clk_sys(clk_sys), .rst_b(rst_b), .excite_out(excite_out),
    .brake_out(brake_out), .decel(decel), .motor_speed(motor_speed));
  initial forever #12.5 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input logic [18:0] seen, input logic [37:0] ent);
    n_checks++;
    if ((seen & ent[37:19]) !== (ent[18:0] & ent[37:19])) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, ent[18:0] & ent[37:19], seen & ent[37:19]);
    end
  endtask
  task automatic wait_c(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    wait_c(1);
    reg_wr <= 1'b0;
    wait_c(1);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    rq.push_back({3'h0, m, 3'h0, e});
    reg_addr <= a;
    reg_rd <= 1'b1;
    wait_c(1);
    reg_rd <= 1'b0;
    wait_c(1);
  endtask
  task automatic probe(input logic [18:0] e);
    pq.push_back({19'h7ffff, e});
    pv <= 1'b1;
    wait_c(1);
    pv <= 1'b0;
    wait_c(1);
  endtask
  task automatic wrap_up();
    n_mismatch += rq.size() + pq.size();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // --------------------------------
  // result watcher and hang limit
  // --------------------------------
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    rd_d <= reg_rd;
    if (rd_d) chk("reg_rdata", {3'h0, reg_rdata}, rq.pop_front());
    if (pv) chk("term_out func_in", {term_out, func_in}, pq.pop_front());
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    v = 16'($urandom(30));
    wait_c(16);
    rst_b <= 1'b1;
    wait_c(1);
    rd(4'h2, `BSIA_RST_BRK_SPEED, 16'hffff);
    rd(4'h3, `BSIA_RST_BRK_TIME, 16'hffff);
    rd(4'h4, `BSIA_RST_IN_ALLOC_LO, 16'hffff);
    rd(4'h5, `BSIA_RST_IN_ALLOC_HI, 16'hffff);
    rd(4'h6, `BSIA_RST_OUT_ALLOC, 16'hffff);
    wr(4'hf, 16'h1234);
    rd(4'hf, 16'h0, 16'hffff);
    wr(4'h7, 16'hffff);
    rd(4'h7, 16'h0040, 16'h0071);
    v = 16'($urandom());
    wr(4'h2, v);
    rd(4'h2, v, 16'hffff);
    clk_en <= 1'b0;
    wr(4'h2, ~v);
    clk_en <= 1'b1;
    rd(4'h2, v, 16'hffff);
    for (int c = 0; c < 16; c++) begin
      status_func <= 11'($urandom());
      wr(4'h6, {4'h0, {3{4'(c)}}});
      wr(4'h8, 16'h1);
      probe({(c == 4 || c > 10) ? 3'h0 : {3{status_func[c]}}, 16'h0});
    end
    status_func <= 11'h0;
    al = 32'h76543210;
    for (int p = 0; p < 2; p++) begin
      if (p == 1) begin
        wr(4'h4, 16'hfedc);
        wr(4'h5, 16'hba98);
        term_in <= 8'h1;
        wait_c(5);
        probe({3'h0, 16'h1});
        wr(4'h8, 16'h1);
        al = 32'hba98fedc;
      end
      for (int i = 0; i < 8; i++) begin
        term_in <= 8'h1 << i;
        wait_c(5);
        probe({3'h0, 16'h1 << al[4*i +: 4]});
      end
    end
    term_in <= 8'h0;
    wr(4'h4, `BSIA_RST_IN_ALLOC_LO);
    wr(4'h5, `BSIA_RST_IN_ALLOC_HI);
    wr(4'h8, 16'h1);
    wr(4'h0, 16'h0064);
    term_in <= 8'h1;
    wait_c(5);
    rd(4'h7, 16'h0011, 16'h0051);
    term_in <= 8'h0;
    wr(4'h6, `BSIA_RST_OUT_ALLOC);
    wr(4'h8, 16'h1);
    for (int k = 0; k < 3; k++) begin
      wr(4'h0, k == 0 ? 16'h0002 : (k == 1 ? 16'hfffe : 16'h0000));
      term_in <= 8'h1;
      wait_c(6);
      rd(4'h7, k == 0 ? 16'h0061 : (k == 1 ? 16'h0051 : 16'h0071), 16'h0071);
      probe({k == 1 ? 3'b000 : 3'b100, 16'h1});
      wait_c(12);
      rd(4'h7, 16'h0071, 16'h0071);
      term_in <= 8'h0;
      wait_c(6);
      rd(4'h7, 16'h0040, 16'h0071);
    end
    wr(4'h1, 16'h0001);
    wr(4'h2, 16'h0100);
    wr(4'h3, 16'h000a);
    for (int k = 0; k < 2; k++) begin
      decel <= (k == 1) ? 8'h01 : 8'h40;
      term_in <= 8'h1;
      wait_c(80);
      term_in <= 8'h0;
      wait_c(8);
      rd(4'h7, 16'h0060, 16'h0071);
      wait_c(k == 1 ? 20 : 8);
      rd(4'h7, k == 1 ? 16'h0060 : 16'h0040, 16'h0071);
      wait_c(30);
      rd(4'h7, 16'h0040, 16'h0071);
    end
    wait_c(4);
    wrap_up();
  end
endmodule
